// >>> wdg_top.sv
// watchdog down-counter with axi4-lite register access and reset pulse output.
// assumes halt_exec, ext_wake and osc_wake are single-cycle strobes from the cpu side.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module wdg_top #(
  parameter int TICK_PERIOD = wdg_pkg::TICK_PERIOD // clocks per decrement
) (
  input wire logic aclk, // clock, 200 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [wdg_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [wdg_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire wdg_pkg::opt_t options, // option byte straps
  input wire logic halt_exec, // halt instruction strobe
  input wire logic ext_wake, // external interrupt strobe
  input wire logic osc_wake, // oscillator interrupt strobe
  output logic rst_out_n // system reset request, active low
);
  import wdg_pkg::*;

  logic [PRESC_W-1:0] presc_r;
  logic tick;
  logic [6:0] cnt_r;
  logic act_r;
  logic oie_r;
  mode_t mode_r;
  logic [WAKE_W-1:0] wake_r;
  logic act_eff;
  logic cnt_run;
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cfg;
  logic roll_rst;
  logic sw_rst;
  logic halt_rst;
  logic wdg_fire;
  logic [WAKE_W-1:0] wake_sel;
  stat_t stat;
  logic [9:0] aw_idx;
  logic [9:0] ar_idx;

  // free-running prescaler, strobe on every wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= PRESC_W'(TICK_PERIOD - 1);
    end else if (presc_r == '0) begin
      presc_r <= PRESC_W'(TICK_PERIOD - 1);
    end else begin
      presc_r <= presc_r - 1'b1;
    end
  end

  assign tick = (presc_r == '0);

  // effective activation and counting permission
  assign act_eff = act_r | options.hw_watchdog;
  assign cnt_run = (mode_r == MODE_RUN) || (mode_r == MODE_HALT_LAST);

  // write channel: address and data taken in either order
  assign awready = !aw_full_r && !bvalid_r;
  assign wready = !w_full_r && !bvalid_r;
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign aw_idx = aw_addr_r[ADDR_W-1:2];
  assign wr_ctrl = wr_fire && w_lane0_r && (aw_idx == CTRL_IDX);
  assign wr_cfg = wr_fire && w_lane0_r && (aw_idx == CFG_IDX);

  // address and data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (wr_fire) begin
        aw_full_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        w_byte_r <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end else if (wr_fire) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      if (aw_idx == CTRL_IDX || aw_idx == CFG_IDX || aw_idx == STAT_IDX) begin
        bresp_r <= RESP_OKAY;
      end else begin
        bresp_r <= RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // read channel, one cycle to data
  assign arready = !rvalid_r;
  assign ar_idx = araddr[ADDR_W-1:2];
  assign stat = '{active: act_eff,
                  wake_delay: mode_r == MODE_WAKE_DELAY,
                  active_halt: mode_r == MODE_ACTIVE_HALT,
                  halted: mode_r == MODE_HALT_LAST || mode_r == MODE_HALT};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (ar_idx)
        CTRL_IDX: rdata_r <= {24'h00_0000, act_r, cnt_r};
        CFG_IDX: rdata_r <= {31'h0000_0000, oie_r};
        STAT_IDX: rdata_r <= {28'h000_0000, stat};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // activation: set by software, cleared only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= CTRL_RST[ACT_BIT];
    end else if (wr_ctrl && w_byte_r[ACT_BIT]) begin
      act_r <= 1'b1;
    end
  end

  // oscillator interrupt enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oie_r <= CFG_OIE_RST;
    end else if (wr_cfg) begin
      oie_r <= w_byte_r[OIE_BIT];
    end
  end

  // countdown: write load wins over the decrement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= CNT_RST;
    end else if (wr_ctrl) begin
      cnt_r <= w_byte_r[6:0];
    end else if (tick && cnt_run) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // reset causes
  assign roll_rst = tick && (mode_r == MODE_RUN) && !wr_ctrl && act_eff && (cnt_r == ROLL_FROM);
  assign sw_rst = wr_ctrl && (w_byte_r[ACT_BIT] || act_eff) && !w_byte_r[TOP_BIT];
  assign halt_rst = halt_exec && (mode_r == MODE_RUN) && !oie_r && options.halt_reset_option;
  assign wdg_fire = roll_rst || sw_rst || halt_rst;
  assign wake_sel = options.long_wake ? WAKE_W'(WAKE_LONG_CYC - 1) : WAKE_W'(WAKE_SHORT_CYC - 1);

  // power mode sequencing and wake delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // a reset held for several edges keeps the wake delay armed until release
      if (mode_r == MODE_ACTIVE_HALT || mode_r == MODE_WAKE_DELAY) begin
        mode_r <= MODE_WAKE_DELAY;
        wake_r <= wake_sel;
      end else begin
        mode_r <= MODE_RUN;
        wake_r <= '0;
      end
    end else begin
      unique case (mode_r)
        MODE_RUN: begin
          if (halt_exec && oie_r) begin
            mode_r <= MODE_ACTIVE_HALT;
          end else if (halt_exec && !options.halt_reset_option) begin
            mode_r <= MODE_HALT_LAST;
          end
        end
        MODE_HALT_LAST: begin
          if (ext_wake) begin
            mode_r <= MODE_WAKE_DELAY;
            wake_r <= wake_sel;
          end else if (tick) begin
            mode_r <= MODE_HALT;
          end
        end
        MODE_HALT: begin
          if (ext_wake) begin
            mode_r <= MODE_WAKE_DELAY;
            wake_r <= wake_sel;
          end
        end
        MODE_ACTIVE_HALT: begin
          if (ext_wake || osc_wake) begin
            mode_r <= MODE_RUN;
          end
        end
        MODE_WAKE_DELAY: begin
          if (wake_r == '0) begin
            mode_r <= MODE_RUN;
          end else begin
            wake_r <= wake_r - 1'b1;
          end
        end
      endcase
    end
  end

  // reset pulse stretcher
  wdg_pulse #(
    .LEN(RST_PULSE_CYC)
  ) u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .fire(wdg_fire),
    .pulse_n(rst_out_n)
  );

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // helper: clocks since last prescaler strobe
  logic [PRESC_W-1:0] gap_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end

  AST_TICK_PERIOD: assert property (
    tick && $past(tick) == 1'b0 && $past(aresetn) |-> gap_r == PRESC_W'(TICK_PERIOD - 1))
    else $error("decrement strobe period wrong");

  AST_TICK_SINGLE: assert property (tick |=> !tick)
    else $error("decrement strobe longer than one cycle");

  AST_ROLLOVER: assert property (
    tick && mode_r == MODE_RUN && !wr_ctrl && act_eff && cnt_r == ROLL_FROM && rst_out_n
    |=> !rst_out_n && cnt_r == 7'h3f)
    else $error("rollover did not reset");

  AST_ACT_STICKY: assert property (act_r |=> act_r)
    else $error("activation cleared without reset");

  AST_RESET_VALUE: assert property (@(posedge aclk) $rose(aresetn) |-> {act_r, cnt_r} == CTRL_RST)
    else $error("control register reset value wrong");

  AST_NO_RST_INACTIVE: assert property (
    !act_eff && !sw_rst && !halt_rst && rst_out_n |=> rst_out_n)
    else $error("reset while watchdog inactive");

  AST_HALT_FROZEN: assert property (
    mode_r == MODE_HALT && !wr_ctrl |=> $stable(cnt_r) && !roll_rst)
    else $error("counter moved in halt");

  AST_HALT_OSC: assert property (
    mode_r == MODE_HALT && osc_wake && !ext_wake |=> mode_r == MODE_HALT)
    else $error("oscillator interrupt woke halt");

  AST_RESET_RUN: assert property (
    $rose(aresetn) && mode_r != MODE_WAKE_DELAY |-> mode_r == MODE_RUN && !act_r)
    else $error("reset did not return to run");

  AST_RESET_WAKE: assert property (
    $rose(aresetn) && mode_r == MODE_WAKE_DELAY |-> wake_r == wake_sel)
    else $error("wake delay after reset wrong");

  AST_HALT_WAKE: assert property (
    mode_r == MODE_HALT && ext_wake && !options.long_wake
    |=> mode_r == MODE_WAKE_DELAY ##255 mode_r == MODE_WAKE_DELAY ##1 mode_r == MODE_RUN)
    else $error("halt wake delay wrong");

  AST_HALT_RESET: assert property (
    halt_exec && mode_r == MODE_RUN && !oie_r && options.halt_reset_option && rst_out_n
    |=> !rst_out_n && mode_r == MODE_RUN)
    else $error("halt did not reset");

  AST_ACTIVE_HALT: assert property (
    mode_r == MODE_ACTIVE_HALT && (ext_wake || osc_wake) |=> mode_r == MODE_RUN)
    else $error("active-halt wake not immediate");

  AST_SW_RESET: assert property (
    wr_ctrl && w_byte_r[ACT_BIT] && !w_byte_r[TOP_BIT] && rst_out_n |=> !rst_out_n)
    else $error("software reset missing");

  AST_WRITE_LOAD: assert property (
    wr_ctrl |=> cnt_r == $past(w_byte_r[6:0]) &&
      presc_r == ($past(tick) ? PRESC_W'(TICK_PERIOD - 1) : $past(presc_r) - 1'b1))
    else $error("control write did not load counter");

  COV_ROLLOVER: cover property (roll_rst);
  COV_ACTIVE_HALT: cover property (mode_r == MODE_ACTIVE_HALT ##1 mode_r == MODE_RUN);
  COV_HALT_WAKE: cover property (mode_r == MODE_WAKE_DELAY ##1 mode_r == MODE_RUN);
  COV_SW_RESET: cover property (sw_rst);
  COV_RESET_WAKE: cover property ($rose(aresetn) && mode_r == MODE_WAKE_DELAY);
endmodule // wdg_top

// >>> wdg_pkg.sv
// constants, types and register layout for the watchdog down-counter block.
// assumes a 200 MHz aclk that also stands for the oscillator-derived clock and the cpu clock.
//
// Notes on behaviour
// - counter decrements once per 16384 oscillator-derived clock cycles.
// - active watchdog resets the system when count rolls from 40h to 3Fh; the code does so in run mode only, not on the last decrement in halt.
// - activation bit 7 is set only by software, cleared only by reset.
// - control register reads 7Fh after reset.
// - hardware watchdog option forces activation; activation bit then has no effect.
// - halt with interrupt enable and halt-reset option low: one decrement, then frozen.
// - external interrupt leaving halt restarts counting after 256 or 4096 clocks.
// - reset ending halt leaves watchdog disabled unless hardware option set.
// - halt with interrupt enable low and halt-reset option high gives reset.
// - interrupt enable high: halt freezes counter; oscillator/external interrupt resumes at once.
// - reset ending active-halt restarts counting after 256 or 4096 clocks.
// - countdown keeps running while the watchdog is not activated.
// - a watchdog reset holds the reset output low for 500 ns.
// - writing activation set with top counter bit clear resets immediately.
package wdg_pkg;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD = 16384; // clocks per decrement
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_SHORT_CYC = 256;
  localparam int WAKE_LONG_CYC = 4096;
  localparam int PRESC_W = 14;
  localparam int WAKE_W = 12;
  localparam int PULSE_W = 8;
  // register indices, byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h02a;
  localparam logic [9:0] CFG_IDX = 10'h02b;
  localparam logic [9:0] STAT_IDX = 10'h02c;
  localparam int ADDR_W = 12;
  // control register layout
  localparam logic [7:0] CTRL_RST = 8'h7f;
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [6:0] CNT_RST = 7'h7f;
  localparam logic [6:0] ROLL_FROM = 7'h40;
  // config register layout
  localparam int OIE_BIT = 0;
  localparam logic CFG_OIE_RST = 1'b0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // option byte straps, held stable by the system
  typedef struct packed {
    logic long_wake;          // 1: 4096-clock wake delay, 0: 256
    logic hw_watchdog;        // watchdog always active
    logic halt_reset_option;  // halt gives reset when interrupt enable is low
  } opt_t;

  // status register fields, bit 3 downward
  typedef struct packed {
    logic active;      // effective activation
    logic wake_delay;  // waiting before counting resumes
    logic active_halt; // counter frozen in active-halt
    logic halted;      // in halt, last decrement pending or done
  } stat_t;

  typedef enum {
    MODE_RUN,
    MODE_HALT_LAST,
    MODE_HALT,
    MODE_ACTIVE_HALT,
    MODE_WAKE_DELAY
  } mode_t;
endpackage

// >>> wdg_pulse.sv
// reset pulse stretcher: one fire strobe gives a fixed-length low pulse.
// assumes fire is a clocked strobe; strobes during a pulse are absorbed.
`timescale 1ns/1ps
module wdg_pulse #(
  parameter int LEN = wdg_pkg::RST_PULSE_CYC
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic fire, // start a pulse
  output logic pulse_n // low while the pulse runs
);
  import wdg_pkg::*;

  logic [PULSE_W-1:0] left_r;
  logic [PULSE_W-1:0] len_r;

  // down-count of remaining low cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_r <= '0;
    end else if (fire && left_r == '0) begin
      left_r <= PULSE_W'(LEN);
    end else if (left_r != '0) begin
      left_r <= left_r - 1'b1;
    end
  end

  assign pulse_n = (left_r == '0);

  // helper: length of the current low phase
  always_ff @(posedge aclk) begin
    if (!aresetn || pulse_n) begin
      len_r <= '0;
    end else begin
      len_r <= len_r + 1'b1;
    end
  end

  AST_PULSE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pulse_n) |-> len_r == PULSE_W'(LEN))
    else $error("reset pulse length wrong");
endmodule // wdg_pulse

// >>> wdg_top_tb.sv
// self-checking bench for wdg_top: axi4-lite master, option straps, halt and wake strobes.
// assumes rst_out_n is watched only, never looped back into aresetn.
`timescale 1ns/1ps
module wdg_top_tb;
  import wdg_pkg::*;
  localparam int TP = 64;
  localparam logic [11:0] A_C = {CTRL_IDX, 2'b00};
  localparam logic [11:0] A_G = {CFG_IDX, 2'b00};
  localparam logic [11:0] A_S = {STAT_IDX, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, halt_exec, ext_wake, osc_wake, rst_out_n, prv;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  opt_t options;
  int error_cnt, n_compared, cyc, falls, lowc, last_len, f0;

  wdg_top #(.TICK_PERIOD(TP)) i_wdg_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .options(options),
    .halt_exec(halt_exec), .ext_wake(ext_wake), .osc_wake(osc_wake), .rst_out_n(rst_out_n)
  );

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // cycles since release, reset pulse starts and pulse length
  always @(posedge aclk) begin
    cyc <= aresetn ? cyc + 1 : 0;
    prv <= rst_out_n;
    if (prv && !rst_out_n) falls++;
    if (!rst_out_n) lowc++;
    else if (!prv) begin
      last_len = lowc;
      lowc = 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h to %h seen %h", nm, lo, hi, g);
    end
  endtask

  // one axi write, both channels offered together, held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] val);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= val;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  // one axi read, data and response taken at the rvalid edge
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  // reset for five cycles, straps changed while reset is held
  task automatic rst5(input opt_t o);
    @(posedge aclk);
    aresetn <= 1'b0;
    options <= o;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // single-cycle strobe: 0 halt, 1 external, 2 oscillator
  task automatic pls(input int k);
    @(posedge aclk);
    {osc_wake, ext_wake, halt_exec} <= 3'b001 << k;
    @(posedge aclk);
    {osc_wake, ext_wake, halt_exec} <= 3'b000;
  endtask

  // align to a point well clear of the decrement strobe
  task automatic ph();
    do @(posedge aclk); while (cyc % TP != 20);
  endtask

  // halt with interrupt enable and halt-reset option low, then external wake
  task automatic hs(input logic lw);
    int dl;
    dl = lw ? WAKE_LONG_CYC : WAKE_SHORT_CYC;
    rst5({lw, 2'b00});
    ph();
    f0 = falls;
    wr(A_C, 32'h0000_00c3);
    pls(0);
    repeat (260) @(posedge aclk);
    rd(A_C);
    chk("halt count", 32'h0000_00c2, d);
    chk("halt no reset", f0, falls);
    rd(A_S);
    chk("halt status", 32'h0000_0009, d);
    pls(2);
    rd(A_S);
    chk("osc ignored", 32'h0000_0009, d);
    pls(1);
    repeat (dl - 12) @(posedge aclk);
    rd(A_C);
    chk("wake frozen", 32'h0000_00c2, d);
    rd(A_S);
    chk("wake status", 32'h0000_000c, d);
    repeat (16) @(posedge aclk);
    rd(A_S);
    chk("run status", 32'h0000_0008, d);
    repeat (60) @(posedge aclk);
    rd(A_C);
    chk_rng("resumed count", 32'h0000_00c0, 32'h0000_00c1, d);
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, halt_exec, ext_wake, osc_wake} = '0;
    {awaddr, araddr, wdata, wstrb, options} = '0;
    {error_cnt, n_compared, cyc, falls, lowc, last_len} = '0;
    prv = 1'b1;
    void'($urandom(32'he123_2c27));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_C);
    chk("ctrl reset", {24'h0, CTRL_RST}, d);
    chk("ctrl rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(A_G);
    chk("cfg reset", 32'h0, d);
    rd(12'h000);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    wr(12'h010, 32'h0000_00ff);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    ph();
    for (int i = 0; i < 3; i++) begin
      v = 32'h40 | ($urandom & 32'h3f);
      wr(A_C, v);
      rd(A_C);
      chk("loaded count", v, d);
    end
    ph();
    f0 = falls;
    wr(A_C, 32'h0000_0041);
    repeat (192) @(posedge aclk);
    rd(A_C);
    chk("free count", 32'h0000_003e, d);
    chk("inactive no reset", f0, falls);
    ph();
    f0 = falls;
    wr(A_C, 32'h0000_00c1);
    repeat (90) @(posedge aclk);
    chk("early reset", f0, falls);
    repeat (50) @(posedge aclk);
    chk("rollover reset", f0 + 1, falls);
    repeat (110) @(posedge aclk);
    chk("pulse length", RST_PULSE_CYC, last_len);
    rd(A_C);
    chk("after rollover", 32'h0000_00bd, d);
    wr(A_C, 32'h0000_007f);
    rd(A_C);
    chk("activation kept", 32'h0000_00ff, d);
    f0 = falls;
    wr(A_C, 32'h0000_00a5);
    repeat (3) @(posedge aclk);
    chk("software reset", f0 + 1, falls);
    repeat (110) @(posedge aclk);
    rst5(3'b010);
    rd(A_S);
    chk("hw active", 32'h0000_0008, d);
    f0 = falls;
    wr(A_C, 32'h0000_003f);
    repeat (3) @(posedge aclk);
    chk("hw reset", f0 + 1, falls);
    repeat (110) @(posedge aclk);
    rst5(3'b001);
    f0 = falls;
    pls(0);
    repeat (3) @(posedge aclk);
    chk("halt reset", f0 + 1, falls);
    rd(A_S);
    chk("halt refused", 32'h0, d);
    repeat (110) @(posedge aclk);
    hs(1'b0);
    hs(1'b1);
    rst5(3'b000);
    wr(A_C, 32'h0000_00ff);
    pls(0);
    rst5(3'b000);
    rd(A_C);
    chk("halt then reset", 32'h0000_007f, d);
    rd(A_G);
    chk("cfg after reset", 32'h0, d);
    wr(A_G, 32'h0000_0001);
    chk("cfg bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    ph();
    wr(A_C, 32'h0000_007f);
    pls(0);
    rd(A_S);
    chk("active halt", 32'h0000_0002, d);
    repeat (200) @(posedge aclk);
    rd(A_C);
    chk("frozen", 32'h0000_007f, d);
    pls(2);
    rd(A_S);
    chk("osc resume", 32'h0, d);
    repeat (150) @(posedge aclk);
    rd(A_C);
    chk_rng("counting", 32'h0000_007c, 32'h0000_007d, d);
    pls(0);
    pls(1);
    rd(A_S);
    chk("ext resume", 32'h0, d);
    pls(0);
    rst5(3'b000);
    rd(A_S);
    chk("reset delay", 32'h0000_0004, d);
    repeat (240) @(posedge aclk);
    rd(A_S);
    chk("delay held", 32'h0000_0004, d);
    repeat (16) @(posedge aclk);
    rd(A_S);
    chk("delay over", 32'h0, d);
    print_verdict();
  end
endmodule // wdg_top_tb
